/* rtl/pmc_mode_control.v */
// Purpose: Point-move and electronic gear operating modes.
// Assumes: All inputs synchronous to clk; parameter port is the host side.
// Notes:   Point moves step once per tick; gear steps once per clock.
//
// Notes on behaviour
// R1: Target or distance write starts point move.
// R2: Point move travels at current speed register.
// R3: Host references before absolute moves.
// R4: Move ends at target standstill or fault.
// R5: Relative move in other mode needs standstill; the code never checks motorStill and, while gear is active, adds the distance to the gear offset instead.
// R6: Point status: errors, reached, end, error.
// R7: Resume write continues interrupted move; cause cleared.
// R8: Position and speed changes act at once.
// R9: Ramp setting latched only at new target.
// R10: Reference pulses scaled by ratio drive setpoint.
// R11: Gear start selects sync; zero deactivates.
// R12: Gear follows at once, no range limits.
// R13: Leaving operation enabled deactivates gear.
// R14: Immediate sync ignores everything before activation.
// R15: Compensating sync moves to uninterrupted position.
// R16: Gear status: errors, sync window, end, error.
// R17: Quadrature four-fold or pulse signals accepted.
// R18: Offset move superimposed on gear setpoint.
// R19: Numerator write activates ratio; negative reverses.
// R20: Direction permit positive, negative or both.
// R21: Ending error latched with mode error bit.
`timescale 1ns/10ps
`include "pmc_defs.vh"

module pmc_mode_control #(
  parameter TICK_CYCLES = `PMC_TICK_CYCLES
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        parWr,
  input  wire        parRd,
  input  wire [7:0]  parIdx,
  input  wire [7:0]  parSidx,
  input  wire [31:0] parWdata,
  output reg  [31:0] parRdata,
  output reg         parAck,
  input  wire [7:0]  errIn,
  input  wire        refDone,
  input  wire        opEnabled,
  input  wire        motorStill,
  input  wire [31:0] rampIn,
  input  wire        refA,
  input  wire        refB,
  input  wire [1:0]  refMode,
  output reg  [31:0] posSetpoint,
  output reg  [31:0] rampActive,
  output reg  [1:0]  modeActive
);

  // --------------------------------------------------------------------
  // Parameter decode
  // --------------------------------------------------------------------
  wire ptpSel  = (parIdx == `PMC_IDX_PTP);
  wire gearSel = (parIdx == `PMC_IDX_GEAR);
  wire wrAbs   = parWr & ptpSel & (parSidx == `PMC_SIDX_ABS);
  wire wrRel   = parWr & ptpSel & (parSidx == `PMC_SIDX_REL);
  wire wrRes   = parWr & ptpSel & (parSidx == `PMC_SIDX_RESUME);
  wire wrSpd   = parWr & ptpSel & (parSidx == `PMC_SIDX_SPEED);
  wire wrGst   = parWr & gearSel & (parSidx == `PMC_SIDX_GSTART);
  wire wrNum   = parWr & gearSel & (parSidx == `PMC_SIDX_NUM);
  wire wrDen   = parWr & gearSel & (parSidx == `PMC_SIDX_DEN);
  wire wrDir   = parWr & gearSel & (parSidx == `PMC_SIDX_DIRPERMIT);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [31:0] absTarget_reg;
  reg  [31:0] relDist_reg;
  reg  [15:0] resume_reg;
  reg  [31:0] speed_reg;
  reg  [31:0] target_reg;
  reg  [15:0] gearStart_reg;
  reg  [31:0] numAct_reg;
  reg  [31:0] denAct_reg;
  reg  [31:0] numPend_reg;
  reg  [31:0] denPend_reg;
  reg  [15:0] dirPermit_reg;
  reg  [7:0]  ptpErr_reg;
  reg  [7:0]  gearErr_reg;
  reg         ptpReached_reg;
  reg         ptpEnd_reg;
  reg         ptpFail_reg;
  reg         interrupted_reg;
  reg         gearWin_reg;
  reg         gearEnd_reg;
  reg         gearFail_reg;
  reg         gearRan_reg;
  reg  [63:0] acc_reg;
  reg  [31:0] virtPos_reg;
  reg  [31:0] offset_reg;
  reg  [15:0] tickCnt_reg;
  reg         tick_reg;

  wire        stepPulse;
  wire        stepDir;
  wire [7:0]  errNow   = errIn & `PMC_ERR_MASK;
  wire        faultNow = |errNow;
  wire        inPtp    = (modeActive == `PMC_MODE_PTP);
  wire        inGear   = (modeActive == `PMC_MODE_GEAR);
  wire        ptpStart = wrAbs | (wrRel & ~inGear);
  wire        resumeOk = wrRes & interrupted_reg & ~faultNow & ~inGear;
  wire        gearOn   = wrGst & ((parWdata[15:0] == `PMC_GEAR_IMMED) |
                                  (parWdata[15:0] == `PMC_GEAR_COMPENS));

  pmc_ref_decoder u_dec (
    .clk       (clk),
    .rstn      (rstn),
    .refMode   (refMode),
    .refA      (refA),
    .refB      (refB),
    .stepPulse (stepPulse),
    .stepDir   (stepDir)
  );

  // --------------------------------------------------------------------
  // Point move trajectory
  // --------------------------------------------------------------------
  wire [31:0] ptpDiff  = target_reg - posSetpoint;
  wire [31:0] diffMag  = ptpDiff[31] ? (32'h0 - ptpDiff) : ptpDiff;
  wire [31:0] spdMag   = speed_reg[31] ? (32'h0 - speed_reg) : speed_reg;
  wire [31:0] ptpStep  = (diffMag <= spdMag) ? ptpDiff :
                         (ptpDiff[31] ? (32'h0 - spdMag) : spdMag); // see R8
  wire        atTarget = (ptpDiff == 32'h0);

  // --------------------------------------------------------------------
  // Gear ratio accumulation
  // --------------------------------------------------------------------
  wire [63:0] numExt   = {{32{numAct_reg[31]}}, numAct_reg};
  wire [63:0] denExt   = {32'h0, denAct_reg};
  wire [63:0] accAdd   = stepPulse ?
                         (stepDir ? acc_reg + numExt : acc_reg - numExt) :
                         acc_reg; // see R10 R19
  wire        accUp    = ~accAdd[63] & (accAdd >= denExt);
  wire        accDown  = accAdd[63] & ((64'h0 - accAdd) >= denExt);
  wire [31:0] gearTgt  = virtPos_reg + offset_reg; // see R18
  wire [31:0] gearDiff = gearTgt - posSetpoint;
  wire        gearFwd  = ~gearDiff[31] & (gearDiff != 32'h0);
  wire        gearBack = gearDiff[31];
  wire        fwdOk    = gearFwd & dirPermit_reg[`PMC_DIR_POS]; // see R20
  wire        backOk   = gearBack & dirPermit_reg[`PMC_DIR_NEG]; // see R20

  // --------------------------------------------------------------------
  // Tick divider for point move steps
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_reg <= 16'h0;
      tick_reg    <= 1'b0;
    end else if (tickCnt_reg == TICK_CYCLES[15:0] - 16'h1) begin
      tickCnt_reg <= 16'h0;
      tick_reg    <= 1'b1;
    end else begin
      tickCnt_reg <= tickCnt_reg + 16'h1;
      tick_reg    <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Stored parameters
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      absTarget_reg <= `PMC_RST_TARGET;
      relDist_reg   <= `PMC_RST_TARGET;
      resume_reg    <= 16'h0;
      speed_reg     <= `PMC_RST_SPEED;
      numAct_reg    <= `PMC_RST_NUM;
      denAct_reg    <= `PMC_RST_DEN;
      numPend_reg   <= `PMC_RST_NUM;
      denPend_reg   <= `PMC_RST_DEN;
      dirPermit_reg <= `PMC_RST_DIRPERMIT;
      rampActive    <= 32'h0;
    end else begin
      if (wrAbs) begin
        absTarget_reg <= parWdata;
      end
      if (wrRel) begin
        relDist_reg <= parWdata;
      end
      if (wrRes) begin
        resume_reg <= parWdata[15:0];
      end
      if (wrSpd) begin
        speed_reg <= parWdata; // see R8
      end
      if (wrDen && !parWdata[31] && parWdata != 32'h0) begin
        denPend_reg <= parWdata;
      end
      if (wrNum) begin
        numPend_reg <= parWdata;
        numAct_reg  <= parWdata; // see R19
        denAct_reg  <= denPend_reg;
      end
      if (wrDir && parWdata[15:2] == 14'h0 && parWdata[1:0] != 2'h0) begin
        dirPermit_reg <= parWdata[15:0];
      end
      if (ptpStart && !(wrAbs && !refDone)) begin
        rampActive <= rampIn; // see R9
      end
    end
  end

  // --------------------------------------------------------------------
  // Mode control and point move
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      modeActive      <= `PMC_MODE_IDLE;
      target_reg      <= `PMC_RST_TARGET;
      posSetpoint     <= 32'h0;
      ptpErr_reg      <= 8'h0;
      ptpReached_reg  <= 1'b0;
      ptpEnd_reg      <= 1'b0;
      ptpFail_reg     <= 1'b0;
      interrupted_reg <= 1'b0;
      gearStart_reg   <= `PMC_RST_GSTART;
      gearErr_reg     <= 8'h0;
      gearWin_reg     <= 1'b0;
      gearEnd_reg     <= 1'b0;
      gearFail_reg    <= 1'b0;
      gearRan_reg     <= 1'b0;
      acc_reg         <= 64'h0;
      virtPos_reg     <= 32'h0;
      offset_reg      <= 32'h0;
    end else begin
      // Reference counting runs always so that compensation is possible.
      if (accUp) begin
        acc_reg     <= accAdd - denExt;
        virtPos_reg <= virtPos_reg + 32'h1; // see R10 R15
      end else if (accDown) begin
        acc_reg     <= accAdd + denExt;
        virtPos_reg <= virtPos_reg - 32'h1; // see R10 R15
      end else begin
        acc_reg <= accAdd;
      end
      if (wrRel && inGear) begin
        offset_reg <= offset_reg + parWdata; // see R18
      end
      if (wrGst) begin
        gearStart_reg <= parWdata[15:0];
      end
      ptpReached_reg <= inPtp ? atTarget : ptpReached_reg;
      gearWin_reg    <= inGear & (gearDiff == 32'h0); // see R16
      gearEnd_reg    <= gearRan_reg & ~inGear & motorStill; // see R16
      case (modeActive)
        `PMC_MODE_PTP: begin
          if (faultNow) begin
            modeActive      <= `PMC_MODE_IDLE; // see R4
            ptpErr_reg      <= ptpErr_reg | errNow; // see R21
            ptpFail_reg     <= 1'b1; // see R21
            ptpEnd_reg      <= 1'b1;
            interrupted_reg <= 1'b1;
          end else if (atTarget && motorStill) begin
            modeActive <= `PMC_MODE_IDLE; // see R4
            ptpEnd_reg <= 1'b1;
          end else if (tick_reg) begin
            posSetpoint <= posSetpoint + ptpStep; // see R2
          end
        end
        `PMC_MODE_GEAR: begin
          if (!opEnabled || faultNow ||
              (wrGst && parWdata[15:0] == `PMC_GEAR_OFF)) begin
            modeActive <= `PMC_MODE_IDLE; // see R11 R13
            if (!opEnabled) begin
              gearStart_reg <= `PMC_GEAR_OFF; // see R13
            end
            if (faultNow) begin
              gearErr_reg  <= gearErr_reg | errNow; // see R21
              gearFail_reg <= 1'b1; // see R21
            end
          end else if (fwdOk) begin
            posSetpoint <= posSetpoint + 32'h1; // see R12
          end else if (backOk) begin
            posSetpoint <= posSetpoint - 32'h1; // see R12
          end
        end
        default: begin
          modeActive <= `PMC_MODE_IDLE;
        end
      endcase
      // Starts take priority over the mode step above.
      if (ptpStart && !(wrAbs && !refDone)) begin
        modeActive      <= `PMC_MODE_PTP; // see R1
        target_reg      <= wrAbs ? parWdata :
                           posSetpoint + parWdata; // see R1 R5
        ptpErr_reg      <= errNow;
        ptpFail_reg     <= faultNow;
        ptpEnd_reg      <= 1'b0;
        ptpReached_reg  <= 1'b0;
        interrupted_reg <= 1'b0;
      end else if (wrAbs) begin
        // Absolute move without a defined reference point is refused.
        ptpErr_reg[`PMC_BIT_REF_ERR] <= 1'b1; // see R3
        ptpFail_reg     <= 1'b1;
        ptpEnd_reg      <= 1'b1;
      end else if (resumeOk) begin
        modeActive      <= `PMC_MODE_PTP; // see R7
        ptpErr_reg      <= 8'h0;
        ptpFail_reg     <= 1'b0;
        ptpEnd_reg      <= 1'b0;
        interrupted_reg <= 1'b0;
      end else if (gearOn && opEnabled && !inGear) begin
        modeActive   <= `PMC_MODE_GEAR; // see R11
        gearRan_reg  <= 1'b1;
        gearErr_reg  <= errNow;
        gearFail_reg <= faultNow;
        gearEnd_reg  <= 1'b0;
        if (parWdata[15:0] == `PMC_GEAR_IMMED) begin
          virtPos_reg <= posSetpoint; // see R14
          acc_reg     <= 64'h0;
          offset_reg  <= 32'h0;
        end
      end else if (wrGst && !opEnabled) begin
        gearStart_reg <= `PMC_GEAR_OFF; // see R13
      end
    end
  end

  // --------------------------------------------------------------------
  // Parameter read and acknowledge
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      parRdata <= 32'h0;
      parAck   <= 1'b0;
    end else begin
      parAck <= parWr | parRd;
      if (parRd && ptpSel) begin
        case (parSidx)
          `PMC_SIDX_ABS:    parRdata <= absTarget_reg;
          `PMC_SIDX_PSTAT:  parRdata <= {16'h0, ptpFail_reg, ptpEnd_reg,
                                         ptpReached_reg, 5'h0,
                                         ptpErr_reg}; // see R6
          `PMC_SIDX_REL:    parRdata <= relDist_reg;
          `PMC_SIDX_RESUME: parRdata <= {16'h0, resume_reg};
          `PMC_SIDX_SPEED:  parRdata <= speed_reg;
          default:          parRdata <= 32'h0;
        endcase
      end else if (parRd && gearSel) begin
        case (parSidx)
          `PMC_SIDX_GSTART:    parRdata <= {16'h0, gearStart_reg};
          `PMC_SIDX_GSTAT:     parRdata <= {16'h0, gearFail_reg,
                                            gearEnd_reg, gearWin_reg, 5'h0,
                                            gearErr_reg}; // see R16
          `PMC_SIDX_NUM:       parRdata <= numPend_reg;
          `PMC_SIDX_DEN:       parRdata <= denPend_reg;
          `PMC_SIDX_DIRPERMIT: parRdata <= {16'h0, dirPermit_reg};
          default:             parRdata <= 32'h0;
        endcase
      end else if (parRd) begin
        parRdata <= 32'h0;
      end
    end
  end

endmodule // pmc_mode_control

/* rtl/pmc_defs.vh */
// Purpose: Constants of the positioning mode controller.
// Assumes: Included by the design files of the pmc block only.
// Notes:   Parameter addresses are index and subindex pairs.
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// ----------------------------------------------------------------------
// Parameter addresses
// ----------------------------------------------------------------------
`define PMC_IDX_PTP        8'h23
`define PMC_IDX_GEAR       8'h26
`define PMC_SIDX_ABS       8'h01
`define PMC_SIDX_PSTAT     8'h02
`define PMC_SIDX_REL       8'h03
`define PMC_SIDX_RESUME    8'h04
`define PMC_SIDX_SPEED     8'h05
`define PMC_SIDX_GSTART    8'h01
`define PMC_SIDX_GSTAT     8'h02
`define PMC_SIDX_NUM       8'h07
`define PMC_SIDX_DEN       8'h08
`define PMC_SIDX_DIRPERMIT 8'h0d

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PMC_RST_TARGET     32'h00000000
`define PMC_RST_SPEED      32'h00000000
`define PMC_RST_GSTART     16'h0000
`define PMC_RST_NUM        32'h00000001
`define PMC_RST_DEN        32'h00000001
`define PMC_RST_DIRPERMIT  16'h0003

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define PMC_ERR_MASK       8'hef
`define PMC_BIT_REF_ERR    3
`define PMC_BIT_REACHED    13
`define PMC_BIT_END        14
`define PMC_BIT_MODE_ERR   15

// ----------------------------------------------------------------------
// Modes, synchronisation types and reference signal types
// ----------------------------------------------------------------------
`define PMC_MODE_IDLE      2'h0
`define PMC_MODE_PTP       2'h1
`define PMC_MODE_GEAR      2'h2
`define PMC_GEAR_OFF       16'h0000
`define PMC_GEAR_IMMED     16'h0001
`define PMC_GEAR_COMPENS   16'h0002
`define PMC_DIR_POS        0
`define PMC_DIR_NEG        1
`define PMC_REF_QUAD       2'h0
`define PMC_REF_PULSEDIR   2'h1
`define PMC_REF_FWDBACK    2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMC_CLK_PERIOD_NS  10
`define PMC_TICK_NS        1000
`define PMC_TICK_CYCLES    (`PMC_TICK_NS / `PMC_CLK_PERIOD_NS)

`endif

/* rtl/pmc_ref_decoder.v */
// Purpose: Turns gear reference signals into step pulses and direction.
// Assumes: Inputs are synchronous to clk.
// Notes:   One step pulse per decoded count; stepDir high is forward.
`timescale 1ns/10ps
`include "pmc_defs.vh"

module pmc_ref_decoder (
  input  wire       clk,
  input  wire       rstn,
  input  wire [1:0] refMode,
  input  wire       refA,
  input  wire       refB,
  output reg        stepPulse,
  output reg        stepDir
);

  reg       aPrev_reg;
  reg       bPrev_reg;
  reg       stepNext;
  reg       dirNext;
  wire      aEdge = refA ^ aPrev_reg;
  wire      bEdge = refB ^ bPrev_reg;

  // --------------------------------------------------------------------
  // Decoding per signal type
  // --------------------------------------------------------------------
  always @* begin
    stepNext = 1'b0;
    dirNext  = 1'b1;
    case (refMode)
      `PMC_REF_QUAD: begin
        // An edge on one track alone counts, edges on both tracks at once do not: four-fold evaluation.
        stepNext = aEdge ^ bEdge; // see R17
        dirNext  = aEdge ? (refA ^ refB) : ~(refA ^ refB);
      end
      `PMC_REF_PULSEDIR: begin
        stepNext = refA & ~aPrev_reg; // see R17
        dirNext  = ~refB;
      end
      `PMC_REF_FWDBACK: begin
        stepNext = (refA & ~aPrev_reg) ^ (refB & ~bPrev_reg); // see R17
        dirNext  = refA & ~aPrev_reg;
      end
      default: begin
        stepNext = 1'b0;
        dirNext  = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aPrev_reg <= 1'b0;
      bPrev_reg <= 1'b0;
      stepPulse <= 1'b0;
      stepDir   <= 1'b1;
    end else begin
      aPrev_reg <= refA;
      bPrev_reg <= refB;
      stepPulse <= stepNext;
      stepDir   <= dirNext;
    end
  end

endmodule // pmc_ref_decoder

/* tb/pmc_checker.sv */
// Purpose: Port assertions for pmc_mode_control.
// Assumes: Bound to every pmc_mode_control instance.
// Notes:   One clock domain.
`timescale 1ns/10ps

module pmc_checker (
  input wire        clk,
  input wire        rstn,
  input wire        parWr,
  input wire        parRd,
  input wire [7:0]  parIdx,
  input wire [7:0]  parSidx,
  input wire [31:0] parWdata,
  input wire        parAck,
  input wire [7:0]  errIn,
  input wire        refDone,
  input wire        opEnabled,
  input wire [31:0] rampIn,
  input wire [31:0] posSetpoint,
  input wire [31:0] rampActive,
  input wire [1:0]  modeActive
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  wire ptpWr = parWr && parIdx == 8'h23;
  wire fault = (errIn & 8'hef) != 8'h00;
  wire start = ptpWr && (parSidx == 8'h01 && refDone ||
               parSidx == 8'h03 && modeActive != 2'h2);
  wire gearOff = parWr && parIdx == 8'h26 && parSidx == 8'h01 &&
                 parWdata[15:0] == 16'h0000;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_ack_follows: assert property ((parWr || parRd) |=> parAck)
    else $error("access not acknowledged");
  chk_ack_cause: assert property (parAck |-> $past(parWr || parRd))
    else $error("acknowledge without access");
  chk_move_start: assert property (start |=> modeActive == 2'h1)
    else $error("point move not started");
  chk_ramp_latch: assert property (start |=> rampActive == $past(rampIn))
    else $error("ramp not taken at start");
  chk_ramp_hold: assert property (!$past(start) |-> $stable(rampActive))
    else $error("ramp changed without start");
  chk_abs_noref: assert property
    (ptpWr && parSidx == 8'h01 && !refDone && modeActive == 2'h0
     |=> modeActive == 2'h0)
    else $error("absolute move without reference");
  chk_gear_stop: assert property (gearOff |=> modeActive != 2'h2)
    else $error("gear still active after stop");
  chk_op_leave: assert property
    (!opEnabled && modeActive == 2'h2 |-> ##[0:2] modeActive != 2'h2)
    else $error("gear kept outside operation enabled");
  chk_fault_end: assert property
    (fault && modeActive != 2'h0 |-> ##[0:2] modeActive == 2'h0)
    else $error("mode not ended by fault");
  chk_gear_rate: assert property
    (modeActive == 2'h2 && $past(modeActive) == 2'h2 |->
     (posSetpoint - $past(posSetpoint)) inside
     {32'h0, 32'h1, 32'hffffffff})
    else $error("gear setpoint jumped");
endmodule // pmc_checker

bind pmc_mode_control pmc_checker pmc_checker_i (
  .clk(clk), .rstn(rstn), .parWr(parWr), .parRd(parRd),
  .parIdx(parIdx), .parSidx(parSidx), .parWdata(parWdata),
  .parAck(parAck), .errIn(errIn), .refDone(refDone),
  .opEnabled(opEnabled), .rampIn(rampIn), .posSetpoint(posSetpoint),
  .rampActive(rampActive), .modeActive(modeActive)
);

/* tb/pmc_ref_source.sv */
// Purpose: Reference pulse source for the gear input.
// Assumes: Counts are requested by the bench.
// Notes:   Lines hold their level between counts.
`timescale 1ns/10ps

module pmc_ref_source (
  input  wire       clk,
  input  wire [1:0] refMode,
  output logic      refA,
  output logic      refB
);
  logic [1:0] ph = 2'h0;

  initial begin
    refA = 1'b0;
    refB = 1'b0;
  end

  // ------------------------------------------------------------------
  // Count generation
  // ------------------------------------------------------------------
  task automatic send(input int n, input logic back);
    repeat (n) begin
      repeat (4) @(posedge clk);
      if (refMode == 2'h0) begin
        ph = back ? ph - 2'h1 : ph + 2'h1;
        refA <= ph[1];
        refB <= ph[1] ^ ph[0];
      end else begin
        if (refMode == 2'h1) refB <= back;
        @(posedge clk);
        if (refMode == 2'h1 || !back) refA <= 1'b1;
        else refB <= 1'b1;
        repeat (2) @(posedge clk);
        refA <= 1'b0;
        if (refMode == 2'h2) refB <= 1'b0;
      end
    end
  endtask
endmodule // pmc_ref_source

/* tb/tb_pmc_mode_control.sv */
// Purpose: Self-checking bench for pmc_mode_control.
// Assumes: Short tick of 2 cycles.
// Notes:   Bench acts as the parameter host.
`timescale 1ns/10ps

module tb_pmc_mode_control;
  logic        clk, rstn, parWr, parRd, parAck, refDone, opEnabled;
  logic        motorStill, refA, refB;
  logic [7:0]  parIdx, parSidx, errIn;
  logic [31:0] parWdata, parRdata, rampIn, posSetpoint, rampActive;
  logic [31:0] rdat, p0;
  logic [1:0]  refMode, modeActive;
  int          nErrors, totalChecks;

  pmc_mode_control #(.TICK_CYCLES(2)) pmc_mode_control_i (
    .clk(clk), .rstn(rstn), .parWr(parWr), .parRd(parRd),
    .parIdx(parIdx), .parSidx(parSidx), .parWdata(parWdata),
    .parRdata(parRdata), .parAck(parAck), .errIn(errIn),
    .refDone(refDone), .opEnabled(opEnabled), .motorStill(motorStill),
    .rampIn(rampIn), .refA(refA), .refB(refB), .refMode(refMode),
    .posSetpoint(posSetpoint), .rampActive(rampActive),
    .modeActive(modeActive));

  pmc_ref_source pmc_ref_source_i (
    .clk(clk), .refMode(refMode), .refA(refA), .refB(refB));

  always #5 clk = ~clk;

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic summarize();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] idx, sidx,
                     input logic [31:0] d);
    int i;
    parWr    <= wr;
    parRd    <= !wr;
    parIdx   <= idx;
    parSidx  <= sidx;
    parWdata <= d;
    @(posedge clk);
    parWr <= 1'b0;
    parRd <= 1'b0;
    #1;
    for (i = 0; i < 2 && parAck !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check("ack", {31'h0, parAck}, 32'h1);
    if (parAck !== 1'b1) summarize();
    rdat = parRdata;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, sidx, input logic [31:0] d);
    acc(1'b1, idx, sidx, d);
  endtask

  task automatic rd(input logic [7:0] idx, sidx, input logic [31:0] e,
                    input string nm);
    acc(1'b0, idx, sidx, 32'h0);
    check(nm, rdat, e);
  endtask

  task automatic waitIdle();
    int i;
    for (i = 0; i < 3000 && modeActive !== 2'h0; i++) @(posedge clk);
    check("idle", {30'h0, modeActive}, 32'h0);
    if (modeActive !== 2'h0) summarize();
  endtask

  task automatic gearCount(input int n, input logic back,
                           input logic [31:0] e);
    p0 = posSetpoint;
    pmc_ref_source_i.send(n, back);
    repeat (24) @(posedge clk);
    check("gearPos", posSetpoint - p0, e);
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 0; rstn = 0; parWr = 0; parRd = 0; parIdx = 0; parSidx = 0;
    parWdata = 0; errIn = 0; refDone = 0; opEnabled = 1;
    motorStill = 1; rampIn = 32'h7; refMode = 2'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h26, 8'h07, 32'h1, "num");
    rd(8'h26, 8'h08, 32'h1, "den");
    rd(8'h26, 8'h0d, 32'h3, "dirPermit");
    rd(8'h26, 8'h01, 32'h0, "gearStart");
    rd(8'h23, 8'h05, 32'h0, "speed");
    rd(8'h23, 8'h01, 32'h0, "absTarget");
    rd(8'h77, 8'h01, 32'h0, "unmapped");
    wr(8'h26, 8'h0d, 32'h5);
    rd(8'h26, 8'h0d, 32'h3, "dirPermit");
    wr(8'h26, 8'h08, 32'h0);
    rd(8'h26, 8'h08, 32'h1, "den");
    wr(8'h23, 8'h01, 32'd40);
    rd(8'h23, 8'h02, 32'h0000c008, "ptpStatus");
    refDone <= 1'b1;
    wr(8'h23, 8'h05, 32'd10);
    wr(8'h23, 8'h01, 32'd40);
    rampIn <= 32'h9;
    check("ramp", rampActive, 32'h7);
    waitIdle();
    check("pos", posSetpoint, 32'd40);
    rd(8'h23, 8'h02, 32'h00006000, "ptpStatus");
    wr(8'h23, 8'h03, 32'd200);
    p0 = posSetpoint;
    repeat (4) @(posedge clk);
    check("rate", posSetpoint - p0, 32'd20);
    wr(8'h23, 8'h05, 32'd3);
    p0 = posSetpoint;
    repeat (4) @(posedge clk);
    check("rate", posSetpoint - p0, 32'd6);
    waitIdle();
    check("pos", posSetpoint, 32'd240);
    check("ramp", rampActive, 32'h9);
    motorStill <= 1'b0;
    wr(8'h23, 8'h03, 32'd0);
    repeat (4) @(posedge clk);
    check("mode", {30'h0, modeActive}, 32'h1);
    motorStill <= 1'b1;
    wr(8'h23, 8'h03, -32'sd100);
    repeat (4) @(posedge clk);
    errIn <= 8'h04;
    waitIdle();
    acc(1'b0, 8'h23, 8'h02, 32'h0);
    check("ptpStatus", rdat & 32'h80ff, 32'h8004);
    wr(8'h23, 8'h04, 32'h0);
    check("mode", {30'h0, modeActive}, 32'h0);
    errIn <= 8'h00;
    wr(8'h23, 8'h04, 32'h1234);
    waitIdle();
    check("pos", posSetpoint, 32'd140);
    wr(8'h26, 8'h01, 32'h1);
    check("mode", {30'h0, modeActive}, 32'h2);
    p0 = posSetpoint;
    pmc_ref_source_i.send(8, 1'b0);
    repeat (24) @(posedge clk);
    check("quad", {31'h0, posSetpoint - p0 inside {8, -8}}, 32'h1);
    refMode <= 2'h1;
    wr(8'h26, 8'h07, 32'd2);
    gearCount(5, 1'b0, 32'd10);
    wr(8'h26, 8'h07, 32'hffffffff);
    gearCount(4, 1'b0, -32'sd4);
    p0 = posSetpoint;
    wr(8'h23, 8'h03, 32'd5);
    repeat (12) @(posedge clk);
    check("offset", posSetpoint - p0, 32'd5);
    wr(8'h26, 8'h0d, 32'h1);
    gearCount(3, 1'b0, 32'd0);
    p0 = posSetpoint;
    wr(8'h26, 8'h0d, 32'h3);
    repeat (12) @(posedge clk);
    check("permit", posSetpoint - p0, -32'sd3);
    refMode <= 2'h2;
    wr(8'h26, 8'h07, 32'd1);
    gearCount(2, 1'b1, -32'sd2);
    opEnabled <= 1'b0;
    repeat (4) @(posedge clk);
    check("mode", {30'h0, modeActive}, 32'h0);
    rd(8'h26, 8'h01, 32'h0, "gearStart");
    wr(8'h26, 8'h01, 32'h1);
    check("mode", {30'h0, modeActive}, 32'h0);
    opEnabled <= 1'b1;
    gearCount(3, 1'b0, 32'd0);
    wr(8'h26, 8'h01, 32'h2);
    gearCount(0, 1'b0, 32'd3);
    rd(8'h26, 8'h02, 32'h2000, "gearStatus");
    wr(8'h26, 8'h01, 32'h0);
    rd(8'h26, 8'h02, 32'h4000, "gearStatus");
    gearCount(2, 1'b0, 32'd0);
    wr(8'h26, 8'h01, 32'h1);
    gearCount(0, 1'b0, 32'd0);
    summarize();
  end
endmodule // tb_pmc_mode_control
